// File: src/grl_ctrl.sv
// Remote/local, talker/listener and service request control for the bus port
// Operation
// - Remote enable alone does not enter remote; listen addressing with it does.
// - Interface clear forces local, talker idle, listener idle, remote/talk/listen indicators off.
// - Interface clear leaves settings, data and event registers untouched.
// - In lockout only output-off works; local key does nothing.
// - Go-to-local or power cycle cancels lockout and restores the panel.
// - Go-to-local moves a remote device to local, keys re-enabled.
// - Device clear empties input buffer, output queue, deferred and blocking commands.
// - Device clear leaves settings and stored measurements alone.
// - Selected device clear acts like device clear only when addressed.
// - Group trigger arms only when the arm source is the bus.
// - Serial poll returns the status byte at any time.
// - Remote locks all keys but local, output, and trigger when manual.
// - Own talk address sets talker; untalk, listen address, clear drop it.
// - Own listen address sets listener; unlisten, talk address, clear drop it.
// - Service request stays until polled or its causes are cleared.
// - Local key cancels remote and clears user message unless locked out.
// - Reading commands are accepted only while in remote.
// - Primary address is programmable 0 to 30 and matched on addresses.
`timescale 1ns/1ns
`default_nettype none
module grl_ctrl #(
  parameter int KEY_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Bus side: decoded lines and command bytes
  input wire logic ren_i,
  input wire logic ifc_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic talk_taken_i,
  output logic [7:0] talk_data_o,
  output logic talk_valid_o,
  output logic srq_o,
  // Measurement engine side
  input wire logic read_req_i,
  output logic read_go_o,
  output logic read_reject_o,
  output logic dev_clear_o,
  output logic arm_event_o,
  // Front panel
  input wire logic [KEY_W-1:0] keys_i,
  input wire logic local_key_i,
  input wire logic output_key_i,
  input wire logic trig_key_i,
  output logic [KEY_W-1:0] keys_o,
  output logic output_key_o,
  output logic trig_key_o,
  output logic msg_clear_o,
  output logic remote_indicator_o,
  output logic talk_indicator_o,
  output logic listen_indicator_o,
  output logic srq_indicator_o
);
  if (KEY_W < 1 || KEY_W > 16) begin : g_key_w_check
    $error("KEY_W must be 1 to 16");
  end

  // One-hot remote/local state
  typedef enum logic [1:0] {
    GRL_LOCAL = 2'b01,
    GRL_REMOTE = 2'b10
  } grl_rl_t;

  grl_rl_t rl_q;
  logic lockout_q, talk_q, listen_q, spoll_q, srq_q, ack_q;
  logic [4:0] addr_q;
  logic [1:0] arm_q;
  logic [6:0] cond_q, cond_prev_q, spoll_bits_q;
  logic [31:0] rdat_q;

  // Address group and match on the command byte
  function automatic logic is_addr(input logic [7:0] b, input logic [2:0] g,
                                   input logic [4:0] a);
    is_addr = cmd_valid_i && (b[7:5] == g) && (b[4:0] == a);
  endfunction

  function automatic logic is_cmd(input logic [7:0] b, input logic [7:0] c);
    is_cmd = cmd_valid_i && (b == c);
  endfunction

  logic my_listen, my_talk, other_talk, unl, unt;
  logic wb_req, wb_wr, remote, cond_rise, poll_read;

  assign my_listen = is_addr(cmd_byte_i, grl_pkg::GRP_LISTEN, addr_q);
  assign my_talk = is_addr(cmd_byte_i, grl_pkg::GRP_TALK, addr_q);
  // A foreign talk address also unaddresses this talker
  assign other_talk = cmd_valid_i && (cmd_byte_i[7:5] == grl_pkg::GRP_TALK)
                      && !my_talk && !is_cmd(cmd_byte_i, grl_pkg::CMD_UNT);
  assign unl = is_cmd(cmd_byte_i, grl_pkg::CMD_UNL);
  assign unt = is_cmd(cmd_byte_i, grl_pkg::CMD_UNT);
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr = wb_req && wb_we_i;
  assign remote = (rl_q == GRL_REMOTE);
  assign cond_rise = |(cond_q & ~cond_prev_q);
  assign poll_read = talk_q && spoll_q && talk_taken_i;

  // Remote/local state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rl_q <= GRL_LOCAL;
    end else begin
      case (rl_q)
        GRL_LOCAL: begin
          if (!ifc_i && ren_i && my_listen) begin
            rl_q <= GRL_REMOTE;
          end
        end
        GRL_REMOTE: begin
          if (ifc_i) begin
            rl_q <= GRL_LOCAL;
          end else if (!ren_i) begin
            rl_q <= GRL_LOCAL;
          end else if (listen_q && is_cmd(cmd_byte_i, grl_pkg::CMD_GTL)) begin
            rl_q <= GRL_LOCAL;
          end else if (local_key_i && !lockout_q) begin
            rl_q <= GRL_LOCAL;
          end
        end
        default: rl_q <= GRL_LOCAL;
      endcase
    end
  end

  // Lockout latch; interface clear does not touch it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lockout_q <= 1'b0;
    end else if (!ren_i) begin
      lockout_q <= 1'b0;
    end else if (is_cmd(cmd_byte_i, grl_pkg::CMD_LLO)) begin
      lockout_q <= 1'b1;
    end else if (listen_q && is_cmd(cmd_byte_i, grl_pkg::CMD_GTL)) begin
      lockout_q <= 1'b0;
    end
  end

  // Talker and listener addressing
  always_ff @(posedge clk_i) begin
    if (rst_i || ifc_i) begin
      talk_q <= 1'b0;
      listen_q <= 1'b0;
    end else if (cmd_valid_i) begin
      if (my_talk) begin
        talk_q <= 1'b1;
        listen_q <= 1'b0;
      end else if (my_listen) begin
        listen_q <= 1'b1;
        talk_q <= 1'b0;
      end else if (unt || other_talk) begin
        talk_q <= 1'b0;
      end else if (unl) begin
        listen_q <= 1'b0;
      end
    end
  end

  // Serial poll mode; poll may run whether or not service was requested
  always_ff @(posedge clk_i) begin
    if (rst_i || ifc_i) begin
      spoll_q <= 1'b0;
    end else if (is_cmd(cmd_byte_i, grl_pkg::CMD_SPE)) begin
      spoll_q <= 1'b1;
    end else if (is_cmd(cmd_byte_i, grl_pkg::CMD_SPD)) begin
      spoll_q <= 1'b0;
    end
  end

  // Service request: a new cause in the poll cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srq_q <= 1'b0;
      cond_prev_q <= '0;
    end else begin
      cond_prev_q <= cond_q;
      if (cond_rise) begin
        srq_q <= 1'b1;
      end else if (poll_read || cond_q == '0) begin
        srq_q <= 1'b0;
      end
    end
  end

  // Status byte driven while polled as talker
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      talk_valid_o <= 1'b0;
      talk_data_o <= '0;
    end else begin
      talk_valid_o <= talk_q && spoll_q && !ifc_i;
      talk_data_o <= {1'b0, srq_q, spoll_bits_q[5:0]};
    end
  end

  // Clears, arming and reading commands toward the engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_clear_o <= 1'b0;
      arm_event_o <= 1'b0;
      read_go_o <= 1'b0;
      read_reject_o <= 1'b0;
    end else begin
      // Engine empties buffers and queues; settings stay put
      dev_clear_o <= is_cmd(cmd_byte_i, grl_pkg::CMD_DCL)
                     || (listen_q && is_cmd(cmd_byte_i,
                                            grl_pkg::CMD_SDC));
      arm_event_o <= listen_q && is_cmd(cmd_byte_i, grl_pkg::CMD_GET)
                     && (arm_q == grl_pkg::GRL_ARM_BUS);
      read_go_o <= read_req_i && remote;
      read_reject_o <= read_req_i && !remote;
    end
  end

  logic [KEY_W-1:0] keys_g;
  logic local_g, output_g, trig_g;

  grl_key_gate #(
    .KEY_W(KEY_W)
  ) u_gate (
    .remote_i(remote),
    .lockout_i(lockout_q),
    .manual_arm_i(arm_q == grl_pkg::GRL_ARM_MANUAL),
    .keys_i(keys_i),
    .local_key_i(local_key_i),
    .output_key_i(output_key_i),
    .trig_key_i(trig_key_i),
    .keys_o(keys_g),
    .local_key_o(local_g),
    .output_key_o(output_g),
    .trig_key_o(trig_g)
  );

  // Panel outputs and indicators, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      keys_o <= '0;
      output_key_o <= 1'b0;
      trig_key_o <= 1'b0;
      msg_clear_o <= 1'b0;
      remote_indicator_o <= 1'b0;
      talk_indicator_o <= 1'b0;
      listen_indicator_o <= 1'b0;
      srq_indicator_o <= 1'b0;
      srq_o <= 1'b0;
    end else begin
      keys_o <= keys_g;
      output_key_o <= output_g;
      trig_key_o <= trig_g;
      msg_clear_o <= remote && local_g && !ifc_i;
      remote_indicator_o <= remote;
      talk_indicator_o <= talk_q;
      listen_indicator_o <= listen_q;
      srq_indicator_o <= srq_q;
      srq_o <= srq_q;
    end
  end

  // Software registers; interface and device clear never reach them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= grl_pkg::ADDR_RESET;
      arm_q <= grl_pkg::GRL_ARM_IMM;
      cond_q <= '0;
      spoll_bits_q <= '0;
    end else if (wb_wr) begin
      case ({wb_adr_i[3:2], 2'b00})
        grl_pkg::REG_CTRL: begin
          if (wb_sel_i[0] && wb_dat_i[4:0] <= grl_pkg::ADDR_MAX) begin
            addr_q <= wb_dat_i[4:0];
          end
          if (wb_sel_i[1]) begin
            arm_q <= wb_dat_i[grl_pkg::CTRL_ARM_LSB +: 2];
          end
        end
        grl_pkg::REG_SRQ_COND: if (wb_sel_i[0]) cond_q <= wb_dat_i[6:0];
        grl_pkg::REG_SPOLL: if (wb_sel_i[0]) spoll_bits_q <= wb_dat_i[6:0];
        default: ;
      endcase
    end
  end

  // Wishbone answer: ack one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= wb_req;
      rdat_q <= '0;
      if (wb_req && !wb_we_i) begin
        case ({wb_adr_i[3:2], 2'b00})
          grl_pkg::REG_CTRL: begin
            rdat_q[grl_pkg::CTRL_ADDR_LSB +: 5] <= addr_q;
            rdat_q[grl_pkg::CTRL_ARM_LSB +: 2] <= arm_q;
          end
          grl_pkg::REG_STATUS: begin
            rdat_q[grl_pkg::ST_REMOTE] <= remote;
            rdat_q[grl_pkg::ST_LOCKOUT] <= lockout_q;
            rdat_q[grl_pkg::ST_TALK] <= talk_q;
            rdat_q[grl_pkg::ST_LISTEN] <= listen_q;
            rdat_q[grl_pkg::ST_SRQ] <= srq_q;
            rdat_q[grl_pkg::ST_SPOLL] <= spoll_q;
          end
          grl_pkg::REG_SRQ_COND: rdat_q[6:0] <= cond_q;
          grl_pkg::REG_SPOLL: begin
            rdat_q[5:0] <= spoll_bits_q[5:0];
            rdat_q[grl_pkg::SPOLL_RQS] <= srq_q;
          end
          default: rdat_q <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
endmodule
`default_nettype wire

// File: src/grl_key_gate.sv
// Front panel key qualification for remote and lockout states
`timescale 1ns/1ns
`default_nettype none
module grl_key_gate #(
  parameter int KEY_W = 8
) (
  input wire logic remote_i,
  input wire logic lockout_i,
  input wire logic manual_arm_i,
  input wire logic [KEY_W-1:0] keys_i,
  input wire logic local_key_i,
  input wire logic output_key_i,
  input wire logic trig_key_i,
  output logic [KEY_W-1:0] keys_o,
  output logic local_key_o,
  output logic output_key_o,
  output logic trig_key_o
);
  // Lockout leaves only the output key, so output can always be shut off
  always_comb begin
    keys_o = keys_i;
    local_key_o = local_key_i;
    output_key_o = output_key_i;
    trig_key_o = trig_key_i;
    if (lockout_i) begin
      keys_o = '0;
      local_key_o = 1'b0;
      trig_key_o = 1'b0;
    end else if (remote_i) begin
      keys_o = '0;
      trig_key_o = trig_key_i & manual_arm_i;
    end
  end
endmodule
`default_nettype wire

// File: src/grl_pkg.sv
// Constants shared by the remote/local control block
package grl_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SRQ_COND = 4'h8;
  localparam logic [3:0] REG_SPOLL = 4'hc;
  // Control register fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_ARM_LSB = 8;
  localparam logic [4:0] ADDR_RESET = 5'h18;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  // Status register fields
  localparam int ST_REMOTE = 0;
  localparam int ST_LOCKOUT = 1;
  localparam int ST_TALK = 2;
  localparam int ST_LISTEN = 3;
  localparam int ST_SRQ = 4;
  localparam int ST_SPOLL = 5;
  // Rqs bit position in the serial poll byte
  localparam int SPOLL_RQS = 6;
  // Arm source encodings
  typedef enum logic [1:0] {
    GRL_ARM_IMM = 2'h0,
    GRL_ARM_BUS = 2'h1,
    GRL_ARM_MANUAL = 2'h2
  } grl_arm_t;
  // Interface message codes, received with attention true
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [7:0] CMD_UNT = 8'h5f;
  localparam logic [2:0] GRP_LISTEN = 3'h1;
  localparam logic [2:0] GRP_TALK = 3'h2;
  // Least interface clear pulse from the controller
  localparam int CLK_HZ = 10000000;
  localparam int IFC_MIN_US = 100;
  localparam int IFC_MIN_CYC = (IFC_MIN_US * (CLK_HZ / 1000000));
endpackage

// File: tb/grl_ctrl_props.sv
// Port assertions for the remote/local control block
`timescale 1ns/1ns
`default_nettype none
module grl_ctrl_props #(
  parameter int KEY_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ren_i,
  input wire logic ifc_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic read_req_i,
  input wire logic read_go_o,
  input wire logic read_reject_o,
  input wire logic dev_clear_o,
  input wire logic arm_event_o,
  input wire logic output_key_i,
  input wire logic output_key_o,
  input wire logic [KEY_W-1:0] keys_o,
  input wire logic remote_indicator_o,
  input wire logic talk_indicator_o,
  input wire logic listen_indicator_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Indicator lags the command by two edges
  a_remote_entry: assert property ($rose(remote_indicator_o) |->
    $past(cmd_valid_i && ren_i && cmd_byte_i[7:5] == 3'h1, 2))
    else $error("remote set without listen address");
  a_ifc_idle: assert property (ifc_i |-> ##2 !(remote_indicator_o ||
    talk_indicator_o || listen_indicator_o))
    else $error("indicators still lit after clear");
  a_read_gate: assert property ($past(read_req_i) |->
    read_go_o == remote_indicator_o && read_reject_o == !remote_indicator_o)
    else $error("read request answered wrongly");
  a_keys_locked: assert property (remote_indicator_o |-> keys_o == '0)
    else $error("key passed in remote");
  a_output_key: assert property (output_key_o == $past(output_key_i))
    else $error("output key not passed");
  a_dcl_pulse: assert property (cmd_valid_i &&
    cmd_byte_i == grl_pkg::CMD_DCL |=> dev_clear_o)
    else $error("no clear pulse after device clear");
  a_arm_cause: assert property (arm_event_o |->
    $past(cmd_valid_i && cmd_byte_i == grl_pkg::CMD_GET))
    else $error("arm event without trigger");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  c_read_go: cover property (read_go_o);
  c_dev_clear: cover property (dev_clear_o);
  c_arm: cover property (arm_event_o);
endmodule
bind grl_ctrl grl_ctrl_props #(.KEY_W(KEY_W)) i_grl_ctrl_props (.*);
`default_nettype wire

// File: tb/grl_host.sv
// Bus controller model driving the decoded bus lines
`timescale 1ns/1ns
`default_nettype none
module grl_host (
  input wire logic clk_i,
  input wire logic talk_valid_i,
  output logic ren_o,
  output logic ifc_o,
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  output logic talk_taken_o
);
  // Idle bus at time zero
  initial begin
    ren_o = 1'b0;
    ifc_o = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'h00;
    talk_taken_o = 1'b0;
  end
  task automatic set_ren(input logic v);
    @(posedge clk_i);
    ren_o <= v;
  endtask
  // Released byte inverted so stale data never looks valid
  task automatic cmd(input logic [7:0] b);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_byte_o <= b;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_byte_o <= ~b;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic clear();
    @(posedge clk_i);
    ifc_o <= 1'b1;
    repeat (grl_pkg::IFC_MIN_CYC) @(posedge clk_i);
    ifc_o <= 1'b0;
  endtask
  // Take one poll byte once it is offered; the bench watchdog ends a hang
  task automatic take();
    while (talk_valid_i !== 1'b1) begin
      @(posedge clk_i);
    end
    talk_taken_o <= 1'b1;
    @(posedge clk_i);
    talk_taken_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the remote/local control block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i, sel_use;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic ren_i, ifc_i, cmd_valid_i, talk_taken_i, talk_valid_o, srq_o;
  logic [7:0] cmd_byte_i, talk_data_o, keys_o, keys_i;
  logic read_req_i, read_go_o, read_reject_o, dev_clear_o;
  logic arm_event_o, local_key_i, output_key_i;
  logic trig_key_i, output_key_o, trig_key_o, msg_clear_o;
  logic remote_indicator_o, talk_indicator_o, listen_indicator_o;
  logic srq_indicator_o;
  int n_mismatch = 0, check_count = 0, n_dc = 0, n_arm = 0;
  int n_go = 0, n_rej = 0, n_msg = 0;
  always #50 clk_i = ~clk_i;
  grl_ctrl #(.KEY_W(8)) i_grl_ctrl (.*);
  grl_host i_grl_host (.clk_i(clk_i), .talk_valid_i(talk_valid_o),
    .ren_o(ren_i), .ifc_o(ifc_i), .cmd_valid_o(cmd_valid_i),
    .cmd_byte_o(cmd_byte_i), .talk_taken_o(talk_taken_i));
  // Pulse counters, so single-cycle outputs are never missed
  always @(posedge clk_i) begin
    n_dc <= n_dc + int'(dev_clear_o);
    n_arm <= n_arm + int'(arm_event_o);
    n_go <= n_go + int'(read_go_o);
    n_rej <= n_rej + int'(read_reject_o);
    n_msg <= n_msg + int'(msg_clear_o);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= sel_use;
    wb_dat_i <= d;
    // No cycle count assumed; only the watchdog ends this wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic st(input logic [31:0] e);
    wb(1'b0, grl_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'h3f, e);
  endtask
  task automatic ctl(input logic [31:0] e);
    wb(1'b0, grl_pkg::REG_CTRL, 32'h0);
    chk(rd & 32'h31f, e);
  endtask
  // Keys up for one cycle; result read two edges on
  task automatic press(input logic [7:0] k, input logic o, t, l);
    @(posedge clk_i);
    keys_i <= k;
    output_key_i <= o;
    trig_key_i <= t;
    local_key_i <= l;
    @(posedge clk_i);
    keys_i <= 8'h00;
    output_key_i <= 1'b0;
    trig_key_i <= 1'b0;
    local_key_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rreq();
    @(posedge clk_i);
    read_req_i <= 1'b1;
    @(posedge clk_i);
    read_req_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_regs();
    st(32'h0);
    ctl(32'h18);
    wb(1'b1, grl_pkg::REG_CTRL, 32'h1f);
    ctl(32'h18);
    // Lane 1 disabled: address moves, arm source stays
    sel_use = 4'h1;
    wb(1'b1, grl_pkg::REG_CTRL, 32'h11d);
    sel_use = 4'h3;
    ctl(32'h1d);
    wb(1'b1, grl_pkg::REG_CTRL, 32'h1e);
    ctl(32'h1e);
    $display("test regs done");
  endtask
  task automatic t_remote();
    i_grl_host.set_ren(1'b1);
    st(32'h0);
    i_grl_host.cmd(8'h3e);
    st(32'h9);
    chk({remote_indicator_o, talk_indicator_o, listen_indicator_o}, 32'h5);
    press(8'hff, 1'b1, 1'b1, 1'b0);
    chk({keys_o, output_key_o, trig_key_o}, 32'h2);
    wb(1'b1, grl_pkg::REG_CTRL, 32'h21e);
    press(8'h00, 1'b0, 1'b1, 1'b0);
    chk(trig_key_o, 32'h1);
    $display("test remote done");
  endtask
  task automatic t_addr();
    i_grl_host.cmd(8'h5e);
    st(32'h5);
    i_grl_host.cmd(8'h3e);
    st(32'h9);
    i_grl_host.cmd(grl_pkg::CMD_UNL);
    st(32'h1);
    i_grl_host.cmd(8'h5e);
    i_grl_host.cmd(grl_pkg::CMD_UNT);
    st(32'h1);
    // A foreign talk address unaddresses this talker too
    i_grl_host.cmd(8'h5e);
    i_grl_host.cmd(8'h45);
    st(32'h1);
    $display("test address done");
  endtask
  task automatic t_lock();
    i_grl_host.cmd(grl_pkg::CMD_LLO);
    press(8'hff, 1'b1, 1'b0, 1'b1);
    chk({keys_o, output_key_o}, 32'h1);
    st(32'h3);
    chk(n_msg, 32'h0);
    i_grl_host.cmd(8'h3e);
    i_grl_host.cmd(grl_pkg::CMD_GTL);
    st(32'h8);
    press(8'hff, 1'b0, 1'b0, 1'b0);
    chk(keys_o, 32'hff);
    i_grl_host.cmd(8'h3e);
    press(8'h00, 1'b0, 1'b0, 1'b1);
    st(32'h8);
    chk(n_msg, 32'h1);
    $display("test lockout done");
  endtask
  task automatic t_ifc();
    i_grl_host.cmd(8'h3e);
    i_grl_host.clear();
    st(32'h0);
    chk({remote_indicator_o, talk_indicator_o, listen_indicator_o}, 32'h0);
    ctl(32'h21e);
    $display("test clear done");
  endtask
  task automatic t_devclr();
    i_grl_host.cmd(grl_pkg::CMD_DCL);
    chk(n_dc, 32'h1);
    i_grl_host.cmd(grl_pkg::CMD_SDC);
    chk(n_dc, 32'h1);
    i_grl_host.cmd(8'h3e);
    i_grl_host.cmd(grl_pkg::CMD_SDC);
    chk(n_dc, 32'h2);
    ctl(32'h21e);
    i_grl_host.cmd(grl_pkg::CMD_GET);
    chk(n_arm, 32'h0);
    wb(1'b1, grl_pkg::REG_CTRL, 32'h11e);
    i_grl_host.cmd(grl_pkg::CMD_GET);
    chk(n_arm, 32'h1);
    rreq();
    chk(n_go, 32'h1);
    i_grl_host.cmd(grl_pkg::CMD_GTL);
    rreq();
    chk({n_go[3:0], n_rej[3:0]}, 32'h11);
    $display("test device clear done");
  endtask
  task automatic t_poll();
    wb(1'b1, grl_pkg::REG_SRQ_COND, 32'h1);
    st(32'h18);
    i_grl_host.cmd(grl_pkg::CMD_SPE);
    i_grl_host.cmd(8'h5e);
    chk({talk_valid_o, talk_data_o[6], srq_o, srq_indicator_o}, 32'hf);
    i_grl_host.take();
    st(32'h24);
    chk(srq_indicator_o, 32'h0);
    chk({talk_valid_o, talk_data_o[6]}, 32'h2);
    i_grl_host.cmd(grl_pkg::CMD_SPD);
    // New cause sets the request again; clearing all causes drops it
    wb(1'b1, grl_pkg::REG_SRQ_COND, 32'h3);
    st(32'h14);
    wb(1'b1, grl_pkg::REG_SRQ_COND, 32'h0);
    st(32'h4);
    $display("test poll done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence after ten reset cycles
  initial begin
    // Idle bus and panel while reset is held
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_adr_i <= 4'h0;
    wb_sel_i <= 4'h0;
    wb_dat_i <= 32'h0;
    keys_i <= 8'h00;
    read_req_i <= 1'b0;
    local_key_i <= 1'b0;
    output_key_i <= 1'b0;
    trig_key_i <= 1'b0;
    sel_use = 4'h3;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_remote();
    t_addr();
    t_lock();
    t_ifc();
    t_devclr();
    t_poll();
    wrap_up();
  end
  // Watchdog: the run needs about 1200 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
